// *** include/fsp_consts.svh ***
// named constants for the flash self-programming sequencer
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// command patterns in the lower six control bits
`define FSP_CMD_LOAD     6'h01
`define FSP_CMD_ERASE    6'h03
`define FSP_CMD_WRITE    6'h05
`define FSP_CMD_FUSE     6'h09
`define FSP_CMD_CLRBUF   6'h11
`define FSP_CMD_SIG      6'h21
`define FSP_CMD_NONE     6'h00

// control register
`define FSP_CTRL_RST     8'h00
`define FSP_EN_BIT       0
`define FSP_CMD_MSB      5

// store window: a store is taken on any of the four cycles after a control write
`define FSP_WINDOW_CYC   3'h4
`define FSP_WIN_ZERO     3'h0
`define FSP_WIN_ONE      3'h1

// pointer fields
`define FSP_BYTE_BIT     0
`define FSP_WORD_LSB     1
`define FSP_WORD_MSB     6
`define FSP_PAGE_LSB     7
`define FSP_PAGE_MSB     13
`define FSP_WORD_W       6
`define FSP_PAGE_W       7
`define FSP_BUF_DEPTH    64

// register byte addresses
`define FSP_ADDR_CTRL    4'h0
`define FSP_ADDR_PTR     4'h4
`define FSP_ADDR_DATA    4'h8
`define FSP_ADDR_STAT    4'hc

// reset and fill values
`define FSP_PTR_RST      16'h0000
`define FSP_DATA_RST     16'h0000
`define FSP_BYTE_RST     8'h00
`define FSP_ERASED_WORD  16'hffff
`define FSP_RDATA_RST    32'h00000000

`endif

// *** include/fsp_pkg.sv ***
// types shared by the flash self-programming sequencer
package fsp_pkg;

	typedef enum logic [1:0] {
		FSP_IDLE  = 2'h0,
		FSP_ERASE = 2'h1,
		FSP_WRITE = 2'h2
	} fsp_state_t;

	typedef struct packed {
		logic       erase;
		logic       write;
		logic [6:0] page;
	} fsp_flash_req_t;

	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writeData;
		logic [3:0]  byteEnable;
	} fsp_avs_req_t;

endpackage : fsp_pkg

// *** rtl/fsp_page_buf.sv ***
// temporary page buffer with per-word loaded flags
`include "fsp_consts.svh"

module fsp_page_buf (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        clearBuf,
	input  wire logic        wrEn,
	input  wire logic [5:0]  wrIdx,
	input  wire logic [15:0] wrData,
	input  wire logic [5:0]  rdIdx,
	output logic      [15:0] rdData,
	output logic             anyLoaded
);
	import fsp_pkg::*;

	logic [15:0] mem [`FSP_BUF_DEPTH];
	logic [`FSP_BUF_DEPTH-1:0] loaded_r;

	// ***********************************
	// per-word loaded flags
	// ***********************************
	genvar gi;
	generate
		for (gi = 0; gi < `FSP_BUF_DEPTH; gi++) begin : g_word
			always_ff @(posedge core_clk) begin
				// a load in the clearing cycle survives the clear
				if (!resetn) begin
					loaded_r[gi] <= 1'b0;
				end else if (wrEn && wrIdx == 6'(gi)) begin
					loaded_r[gi] <= 1'b1;
				end else if (clearBuf) begin
					loaded_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// a second load to a loaded word does not take unless clearBuf is high in the same cycle
	always_ff @(posedge core_clk) begin
		if (wrEn && (clearBuf || !loaded_r[wrIdx])) begin
			mem[wrIdx] <= wrData;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdData <= `FSP_ERASED_WORD;
		end else begin
			rdData <= loaded_r[rdIdx] ? mem[rdIdx] : `FSP_ERASED_WORD;
		end
	end

	assign anyLoaded = |loaded_r;

	// ***********************************
	// checks
	// ***********************************
	property p_clear_empties;
		@(posedge core_clk) disable iff (!resetn)
		clearBuf |=> (anyLoaded == $past(wrEn));
	endproperty
	a_clear_empties: assert property (p_clear_empties) else $error("buffer not empty after clear");

	property p_second_load;
		@(posedge core_clk) disable iff (!resetn)
		(wrEn && !clearBuf && loaded_r[wrIdx]) |=> (mem[$past(wrIdx)] == $past(mem[wrIdx]));
	endproperty
	a_second_load: assert property (p_second_load) else $error("second load overwrote word");

endmodule : fsp_page_buf

// *** rtl/fsp_sequencer.sv ***
// flash self-programming sequencer with register slave and cpu stall
`include "fsp_consts.svh"

// Functional notes
// - control holds erase code and store within four cycles starts page erase.
// - erase takes only the page field of the pointer.
// - cpu stays halted for the whole page erase.
// - load code plus store within four cycles puts data pair into buffer.
// - buffer slot for a load comes from the word field only.
// - buffer clears after every page write and on clear-buffer command.
// - buffer clears on system reset.
// - an eeprom write during loading discards all loaded words.
// - write code plus store within four cycles programs buffer into page.
// - cpu stays halted for the whole page write.
// - pointer is high byte over low byte, sixteen bits.
// - word address splits into word-in-page low bits and page high bits.
// - byte load uses pointer bit zero to pick low or high byte.
// - buffer loads accepted in any word order.
// - enable clears after a store or four idle cycles; held during erase/write.
// - control writes other than the defined patterns have no effect.
// - eeprom write in progress blocks all self-programming.
module fsp_sequencer (
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire fsp_pkg::fsp_avs_req_t avsReq,
	output logic               [31:0]  avsReadData,
	output logic                       avsWaitRequest,
	input  wire logic                  progStore,
	input  wire logic                  progLoad,
	input  wire logic                  eepromBusy,
	output logic                       cpuStall,
	output logic               [7:0]   loadByte,
	output logic               [14:0]  flashWordAddr,
	input  wire logic          [15:0]  flashRdWord,
	output fsp_pkg::fsp_flash_req_t    flashReq,
	input  wire logic                  flashDone,
	input  wire logic          [5:0]   flashBufIdx,
	output logic               [15:0]  flashBufWord
);
	import fsp_pkg::*;

	fsp_state_t  state_r;
	logic [7:0]  ctrl_r;
	logic [2:0]  win_r;
	logic [15:0] ptr_r;
	logic [15:0] data_r;
	logic        ack_r;
	logic        wrTake;
	logic        ctrlWr;
	logic        ctrlLegal;
	logic [5:0]  cmd;
	logic        storeTake;
	logic        loadTake;
	logic        clearBuf;
	logic        anyLoaded;
	logic [6:0]  ptrPage;
	logic [5:0]  ptrWord;

	// ***********************************
	// pointer fields
	// ***********************************
	assign ptrPage = ptr_r[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
	assign ptrWord = ptr_r[`FSP_WORD_MSB:`FSP_WORD_LSB];
	assign cmd     = ctrl_r[`FSP_CMD_MSB:0];

	// ***********************************
	// register slave
	// ***********************************
	assign avsWaitRequest = (avsReq.read || avsReq.write) && !ack_r;
	assign wrTake         = avsReq.write && ack_r;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avsReq.read || avsReq.write) && !ack_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			avsReadData <= `FSP_RDATA_RST;
		end else if (avsReq.read && !ack_r) begin
			unique case (avsReq.address)
				`FSP_ADDR_CTRL: avsReadData <= {24'h000000, ctrl_r};
				`FSP_ADDR_PTR:  avsReadData <= {16'h0000, ptr_r};
				`FSP_ADDR_DATA: avsReadData <= {16'h0000, data_r};
				`FSP_ADDR_STAT: avsReadData <= {29'h00000000, eepromBusy, cpuStall, anyLoaded};
				default:        avsReadData <= `FSP_RDATA_RST;
			endcase
		end
	end

	// pointer as high byte over low byte
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ptr_r <= `FSP_PTR_RST;
		end else if (wrTake && avsReq.address == `FSP_ADDR_PTR) begin
			if (avsReq.byteEnable[1]) begin
				ptr_r[15:8] <= avsReq.writeData[15:8];
			end
			if (avsReq.byteEnable[0]) begin
				ptr_r[7:0] <= avsReq.writeData[7:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			data_r <= `FSP_DATA_RST;
		end else if (wrTake && avsReq.address == `FSP_ADDR_DATA) begin
			if (avsReq.byteEnable[1]) begin
				data_r[15:8] <= avsReq.writeData[15:8];
			end
			if (avsReq.byteEnable[0]) begin
				data_r[7:0] <= avsReq.writeData[7:0];
			end
		end
	end

	// ***********************************
	// control register and store window
	// ***********************************
	always_comb begin
		unique case (avsReq.writeData[`FSP_CMD_MSB:0])
			`FSP_CMD_LOAD, `FSP_CMD_ERASE, `FSP_CMD_WRITE,
			`FSP_CMD_FUSE, `FSP_CMD_CLRBUF, `FSP_CMD_SIG: ctrlLegal = 1'b1;
			default: ctrlLegal = 1'b0;
		endcase
	end

	assign ctrlWr = wrTake && avsReq.address == `FSP_ADDR_CTRL && avsReq.byteEnable[0]
		&& ctrlLegal && !eepromBusy && state_r == FSP_IDLE;
	assign storeTake = progStore && win_r != `FSP_WIN_ZERO && state_r == FSP_IDLE && !eepromBusy;
	assign loadTake  = storeTake && cmd == `FSP_CMD_LOAD;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctrl_r <= `FSP_CTRL_RST;
			win_r  <= `FSP_WIN_ZERO;
		end else if (ctrlWr) begin
			ctrl_r <= {2'h0, avsReq.writeData[`FSP_CMD_MSB:0]};
			win_r  <= `FSP_WINDOW_CYC;
		end else if (state_r != FSP_IDLE) begin
			if (flashDone) begin
				ctrl_r <= `FSP_CTRL_RST;
			end
		end else if (storeTake) begin
			win_r <= `FSP_WIN_ZERO;
			if (cmd != `FSP_CMD_ERASE && cmd != `FSP_CMD_WRITE) begin
				ctrl_r <= `FSP_CTRL_RST;
			end
		end else if (win_r != `FSP_WIN_ZERO) begin
			win_r <= win_r - `FSP_WIN_ONE;
			if (win_r == `FSP_WIN_ONE) begin
				ctrl_r <= `FSP_CTRL_RST;
			end
		end
	end

	// ***********************************
	// erase / write sequencing
	// ***********************************
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r <= FSP_IDLE;
		end else begin
			unique case (state_r)
				FSP_IDLE: begin
					if (storeTake && cmd == `FSP_CMD_ERASE) begin
						state_r <= FSP_ERASE;
					end else if (storeTake && cmd == `FSP_CMD_WRITE) begin
						state_r <= FSP_WRITE;
					end
				end
				FSP_ERASE, FSP_WRITE: begin
					if (flashDone) begin
						state_r <= FSP_IDLE;
					end
				end
				default: state_r <= FSP_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			flashReq <= '0;
		end else if (state_r == FSP_IDLE && storeTake
				&& (cmd == `FSP_CMD_ERASE || cmd == `FSP_CMD_WRITE)) begin
			flashReq.erase <= cmd == `FSP_CMD_ERASE;
			flashReq.write <= cmd == `FSP_CMD_WRITE;
			flashReq.page  <= ptrPage;
		end else if (flashDone) begin
			flashReq <= '0;
		end
	end

	assign cpuStall = state_r != FSP_IDLE;

	// ***********************************
	// page buffer
	// ***********************************
	assign clearBuf = (state_r == FSP_WRITE && flashDone)
		|| (ctrlWr && avsReq.writeData[`FSP_CMD_MSB:0] == `FSP_CMD_CLRBUF)
		|| (eepromBusy && anyLoaded);

	fsp_page_buf u_buf (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.clearBuf  (clearBuf),
		.wrEn      (loadTake),
		.wrIdx     (ptrWord),
		.wrData    (data_r),
		.rdIdx     (flashBufIdx),
		.rdData    (flashBufWord),
		.anyLoaded (anyLoaded)
	);

	// ***********************************
	// byte-wise program load
	// ***********************************
	assign flashWordAddr = ptr_r[15:1];

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			loadByte <= `FSP_BYTE_RST;
		end else if (progLoad) begin
			loadByte <= ptr_r[`FSP_BYTE_BIT] ? flashRdWord[15:8] : flashRdWord[7:0];
		end
	end

	// ***********************************
	// checks
	// ***********************************
	property p_erase_start;
		@(posedge core_clk) disable iff (!resetn)
		(storeTake && cmd == `FSP_CMD_ERASE) |=> (cpuStall && flashReq.erase && flashReq.page == $past(ptrPage));
	endproperty
	a_erase_start: assert property (p_erase_start) else $error("erase not started");

	property p_erase_page;
		@(posedge core_clk) disable iff (!resetn)
		(state_r == FSP_ERASE && $stable(state_r)) |-> $stable(flashReq.page);
	endproperty
	a_erase_page: assert property (p_erase_page) else $error("erase page moved");

	property p_stall_hold;
		@(posedge core_clk) disable iff (!resetn)
		(flashReq.erase || flashReq.write) |-> (cpuStall && ctrl_r[`FSP_EN_BIT]);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stall or enable dropped in operation");

	property p_write_done;
		@(posedge core_clk) disable iff (!resetn)
		(state_r == FSP_WRITE && flashDone) |=> (!cpuStall && !anyLoaded && ctrl_r == `FSP_CTRL_RST);
	endproperty
	a_write_done: assert property (p_write_done) else $error("write end not clean");

	property p_write_start;
		@(posedge core_clk) disable iff (!resetn)
		(storeTake && cmd == `FSP_CMD_WRITE) |=> (state_r == FSP_WRITE && flashReq.write) [*2];
	endproperty
	a_write_start: assert property (p_write_start) else $error("write not started");

	property p_load_slot;
		@(posedge core_clk) disable iff (!resetn)
		loadTake |=> (anyLoaded && ctrl_r == `FSP_CTRL_RST);
	endproperty
	a_load_slot: assert property (p_load_slot) else $error("load did not land");

	property p_window;
		@(posedge core_clk) disable iff (!resetn)
		(ctrlWr && avsReq.writeData[`FSP_CMD_MSB:0] != `FSP_CMD_CLRBUF) ##1 (!progStore && !ctrlWr) [*4]
			|=> ctrl_r == `FSP_CTRL_RST;
	endproperty
	a_window: assert property (p_window) else $error("enable outlived window");

	property p_illegal;
		@(posedge core_clk) disable iff (!resetn)
		(wrTake && avsReq.address == `FSP_ADDR_CTRL && !ctrlLegal && win_r == `FSP_WIN_ZERO
			&& state_r == FSP_IDLE) |=> ctrl_r == $past(ctrl_r);
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal pattern took effect");

	property p_eeprom_block;
		@(posedge core_clk) disable iff (!resetn)
		(eepromBusy && progStore && state_r == FSP_IDLE) |=> (state_r == FSP_IDLE);
	endproperty
	a_eeprom_block: assert property (p_eeprom_block) else $error("store ran during eeprom write");

	property p_eeprom_discard;
		@(posedge core_clk) disable iff (!resetn)
		(eepromBusy && anyLoaded) |=> !anyLoaded;
	endproperty
	a_eeprom_discard: assert property (p_eeprom_discard) else $error("loaded words kept");

	property p_byte_pick;
		@(posedge core_clk) disable iff (!resetn)
		progLoad |=> loadByte == ($past(ptr_r[`FSP_BYTE_BIT]) ? $past(flashRdWord[15:8]) : $past(flashRdWord[7:0]));
	endproperty
	a_byte_pick: assert property (p_byte_pick) else $error("wrong byte loaded");

	c_erase: cover property (@(posedge core_clk) disable iff (!resetn) state_r == FSP_ERASE ##1 state_r == FSP_IDLE);
	c_write: cover property (@(posedge core_clk) disable iff (!resetn) state_r == FSP_WRITE && flashDone);
	c_load:  cover property (@(posedge core_clk) disable iff (!resetn) loadTake);
	c_expire: cover property (@(posedge core_clk) disable iff (!resetn)
		win_r == `FSP_WIN_ONE && !progStore);

endmodule : fsp_sequencer

// *** test/fsp_flash_model.sv ***
// flash array model answering the sequencer's erase and write requests
module fsp_flash_model (
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	input  wire fsp_pkg::fsp_flash_req_t flashReq,
	input  wire logic [14:0]             flashWordAddr,
	input  wire logic [15:0]             flashBufWord,
	input  wire logic [7:0]              busyCycles,
	output logic      [15:0]             flashRdWord,
	output logic                         flashDone,
	output logic      [5:0]              flashBufIdx
);
	timeunit 1ns;
	timeprecision 1ps;
	import fsp_pkg::*;

	logic [15:0] mem [0:8191];
	logic [7:0]  cnt_r;

	// ****************************************
	// array contents and read port
	// ****************************************
	assign flashBufIdx = cnt_r[5:0];
	assign flashRdWord = mem[flashWordAddr[12:0]];

	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 16'(i) ^ 16'h5a5a;
		end
	end

	// ****************************************
	// operation timing, slow when busyCycles is large
	// ****************************************
	always @(posedge core_clk) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
			flashDone <= 1'b0;
		end else begin
			flashDone <= 1'b0;
			if ((flashReq.erase || flashReq.write) && !flashDone) begin
				cnt_r <= cnt_r + 8'h01;
				if (cnt_r != 8'h00 && cnt_r <= 8'h40) begin
					mem[{flashReq.page, 6'(cnt_r - 8'h01)}] <= flashReq.write ? flashBufWord : 16'hffff;
				end
				if (cnt_r >= 8'h40 && cnt_r >= busyCycles) begin
					flashDone <= 1'b1;
					cnt_r <= 8'h00;
				end
			end
		end
	end
endmodule : fsp_flash_model

// *** test/test_flash_self_programming.sv ***
// self-checking bench for the flash self-programming sequencer
`include "fsp_consts.svh"

module test_flash_self_programming;
	timeunit 1ns;
	timeprecision 1ps;
	import fsp_pkg::*;

	logic           core_clk;
	logic           resetn;
	fsp_avs_req_t   avsReq;
	logic [31:0]    avsReadData;
	logic           avsWaitRequest;
	logic           progStore;
	logic           progLoad;
	logic           eepromBusy;
	logic           cpuStall;
	logic [7:0]     loadByte;
	logic [14:0]    flashWordAddr;
	logic [15:0]    flashRdWord;
	fsp_flash_req_t flashReq;
	logic           flashDone;
	logic [5:0]     flashBufIdx;
	logic [15:0]    flashBufWord;
	logic [7:0]     busyCycles;
	logic [3:0]     busBe;
	int             nErrors;
	int             samplesChecked;
	logic [5:0]     codes [5] = '{6'h07, 6'h3f, 6'h02, 6'h09, 6'h21};

	fsp_sequencer DUT (.core_clk(core_clk), .resetn(resetn), .avsReq(avsReq), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .progStore(progStore), .progLoad(progLoad), .eepromBusy(eepromBusy),
		.cpuStall(cpuStall), .loadByte(loadByte), .flashWordAddr(flashWordAddr), .flashRdWord(flashRdWord),
		.flashReq(flashReq), .flashDone(flashDone), .flashBufIdx(flashBufIdx), .flashBufWord(flashBufWord));

	fsp_flash_model partner (.core_clk(core_clk), .resetn(resetn), .flashReq(flashReq),
		.flashWordAddr(flashWordAddr), .flashBufWord(flashBufWord), .busyCycles(busyCycles),
		.flashRdWord(flashRdWord), .flashDone(flashDone), .flashBufIdx(flashBufIdx));

	// ****************************************
	// report and compare
	// ****************************************
	task automatic endSim();
		$display("errors %0d, checks %0d", nErrors, samplesChecked);
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : endSim

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic hang();
		nErrors++;
		$display("wait ran out at %0t", $time);
		endSim();
	endtask : hang

	// ****************************************
	// bus, store and load tasks
	// ****************************************
	task automatic busXfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		avsReq.address <= a;
		avsReq.read <= !wr;
		avsReq.write <= wr;
		avsReq.writeData <= d;
		avsReq.byteEnable <= busBe;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (avsWaitRequest !== 1'b0 && k < 20);
		if (avsWaitRequest !== 1'b0) hang();
		q = avsReadData;
		avsReq.read <= 1'b0;
		avsReq.write <= 1'b0;
		@(posedge core_clk);
	endtask : busXfer

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		busXfer(1'b1, a, d, q);
	endtask : wr

	task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		busXfer(1'b0, a, 32'h0, q);
		cmp(q, exp);
	endtask : rdChk

	task automatic storeChk(input logic expStall, input logic [6:0] expPage);
		int k;
		progStore <= 1'b1;
		@(posedge core_clk);
		progStore <= 1'b0;
		@(negedge core_clk);
		cmp({31'h0, cpuStall}, {31'h0, expStall});
		if (expStall) cmp({25'h0, flashReq.page}, {25'h0, expPage});
		k = 0;
		while (cpuStall === 1'b1 && k < 400) begin
			@(negedge core_clk);
			k++;
		end
		if (cpuStall !== 1'b0) hang();
		if (expStall) cmp({31'h0, k > 60}, 32'h1);
		@(posedge core_clk);
	endtask : storeChk

	task automatic loadWord(input logic [5:0] w, input logic [15:0] d);
		wr(`FSP_ADDR_PTR, {16'h0, 2'h2, 7'h55, w, 1'b1});
		wr(`FSP_ADDR_DATA, {16'h0, d});
		wr(`FSP_ADDR_CTRL, 32'h01);
		storeChk(1'b0, 7'h00);
	endtask : loadWord

	task automatic byteChk(input logic [15:0] p, input logic [7:0] exp);
		wr(`FSP_ADDR_PTR, {16'h0, p});
		progLoad <= 1'b1;
		@(posedge core_clk);
		progLoad <= 1'b0;
		@(negedge core_clk);
		cmp({24'h0, loadByte}, {24'h0, exp});
		@(posedge core_clk);
	endtask : byteChk

	// ****************************************
	// clock and test sequence
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	initial begin
		resetn = 1'b0;
		avsReq = '0;
		progStore = 1'b0;
		progLoad = 1'b0;
		eepromBusy = 1'b0;
		busyCycles = 8'h00;
		busBe = 4'h3;
		nErrors = 0;
		samplesChecked = 0;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		cmp({16'h0, flashBufWord}, 32'h0000ffff);
		cmp({31'h0, cpuStall}, 32'h0);
		@(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rdChk(`FSP_ADDR_CTRL, 32'h0);
		rdChk(`FSP_ADDR_STAT, 32'h0);
		rdChk(4'h2, 32'h0);
		wr(`FSP_ADDR_PTR, 32'h0000abcd);
		rdChk(`FSP_ADDR_PTR, 32'h0000abcd);
		busBe = 4'h2;
		wr(`FSP_ADDR_PTR, 32'h00001200);
		wr(`FSP_ADDR_CTRL, 32'h01);
		busBe = 4'h3;
		rdChk(`FSP_ADDR_PTR, 32'h000012cd);
		rdChk(`FSP_ADDR_CTRL, 32'h0);
		byteChk(16'h0008, 8'h5e);
		byteChk(16'h0009, 8'h5a);
		wr(`FSP_ADDR_CTRL, 32'h01);
		rdChk(`FSP_ADDR_CTRL, 32'h01);
		@(posedge core_clk);
		storeChk(1'b0, 7'h00);
		rdChk(`FSP_ADDR_STAT, 32'h0);
		foreach (codes[i]) begin
			wr(`FSP_ADDR_CTRL, {26'h0, codes[i]});
			rdChk(`FSP_ADDR_CTRL, (codes[i] == 6'h09 || codes[i] == 6'h21) ? {26'h0, codes[i]} : 32'h0);
			storeChk(1'b0, 7'h00);
		end
		loadWord(6'h05, 16'ha005);
		rdChk(`FSP_ADDR_CTRL, 32'h0);
		rdChk(`FSP_ADDR_STAT, 32'h1);
		loadWord(6'h00, 16'ha000);
		loadWord(6'h3f, 16'ha03f);
		loadWord(6'h05, 16'hbeef);
		busyCycles <= 8'h96;
		wr(`FSP_ADDR_PTR, {16'h0, 2'h3, 7'h03, 6'h2a, 1'b1});
		wr(`FSP_ADDR_CTRL, 32'h03);
		storeChk(1'b1, 7'h03);
		byteChk(16'h0182, 8'hff);
		byteChk(16'h0208, 8'h5e);
		busyCycles <= 8'h00;
		wr(`FSP_ADDR_PTR, 32'h00000180);
		wr(`FSP_ADDR_CTRL, 32'h05);
		storeChk(1'b1, 7'h03);
		rdChk(`FSP_ADDR_STAT, 32'h0);
		byteChk(16'h018a, 8'h05);
		byteChk(16'h018b, 8'ha0);
		byteChk(16'h0180, 8'h00);
		byteChk(16'h01fe, 8'h3f);
		byteChk(16'h0182, 8'hff);
		loadWord(6'h07, 16'h1111);
		wr(`FSP_ADDR_CTRL, 32'h11);
		rdChk(`FSP_ADDR_STAT, 32'h0);
		loadWord(6'h09, 16'h2222);
		eepromBusy <= 1'b1;
		@(posedge core_clk);
		eepromBusy <= 1'b0;
		rdChk(`FSP_ADDR_STAT, 32'h0);
		eepromBusy <= 1'b1;
		wr(`FSP_ADDR_CTRL, 32'h03);
		storeChk(1'b0, 7'h00);
		rdChk(`FSP_ADDR_CTRL, 32'h0);
		rdChk(`FSP_ADDR_STAT, 32'h4);
		eepromBusy <= 1'b0;
		loadWord(6'h0a, 16'h3333);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rdChk(`FSP_ADDR_STAT, 32'h0);
		endSim();
	end
endmodule : test_flash_self_programming
